// >>> src/mci_top.sv
`timescale 1ns/1ps
module mci_top
	import mci_pkg::*;
#(
	parameter int              TICK_DIV = mci_pkg::TICK_CYCLES, // cycles per 100us
	parameter logic [15:0]     FW_VER   = 16'h0100,             // arbitrary value
	parameter logic [15:0]     HW_VER   = 16'h0100              // arbitrary value
)(
	input  wire logic            i_clk,             // system clock
	input  wire logic            i_srst,            // sync reset
	input  wire logic            i_wr,              // write strobe
	input  wire logic            i_rd,              // read strobe
	input  wire logic [1:0]      i_addr,            // byte select
	input  wire logic [7:0]      i_wdata,           // write data
	output logic      [7:0]      o_rdata,           // read data, next cycle
	input  wire logic [7:0]      i_isolated_input,  // input pins
	input  wire logic [3:0]      i_board_ident,     // board id straps
	output logic                 o_pulse_out_0,     // pwm 0
	output logic                 o_pulse_out_1,     // pwm 1
	output logic      [7:0]      o_filter_en,       // filter enables
	output logic                 o_pattern_match,   // pattern matched level
	output logic                 o_edge_irq         // edge seen, one cycle
);
	import mci_pkg::*;

	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		logic [7:0]  param_low;
		logic [7:0]  param_high;
		logic [7:0]  code;
		logic        req;
		logic [7:0]  reply_low;
		logic [7:0]  reply_high;
		logic [7:0]  reply_echo;
		logic [7:0]  rdata;
		logic [7:0]  in_s1;
		logic [7:0]  in_s2;
		logic [7:0]  in_prev;
		logic [3:0]  id_s1;
		logic [3:0]  id_s2;
		logic [15:0] tick_cnt;
		logic        tick;
		logic [15:0] hi0;
		logic [15:0] lo0;
		logic [15:0] hi1;
		logic [15:0] lo1;
		logic [15:0] burst0;
		logic [15:0] burst1;
		logic [1:0]  pwm_en;
		logic [1:0]  start;
		logic [1:0]  stop;
		logic [7:0]  filter;
		logic [7:0]  pat_en;
		logic [7:0]  pat_val;
		logic [7:0]  rise_en;
		logic [7:0]  fall_en;
		logic        match;
		logic        irq;
	} mci_st_t;

	mci_st_t     st_ff;
	mci_st_t     nxt_st;
	logic [1:0]  pwm_pulse;
	logic [1:0]  pwm_done;

	localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);

	// ************************************************
	// helpers
	// ************************************************
	function automatic logic [15:0] word16(input logic [7:0] hi, input logic [7:0] lo);
		word16 = {hi, lo};
	endfunction

	// readback of a setting by its command code; unknown codes read zero
	function automatic logic [15:0] setting_of(input mci_st_t s, input logic [7:0] c);
		case (c)
			C_HI0:    setting_of = s.hi0;
			C_LO0:    setting_of = s.lo0;
			C_HI1:    setting_of = s.hi1;
			C_LO1:    setting_of = s.lo1;
			C_BURST0: setting_of = s.burst0;
			C_BURST1: setting_of = s.burst1;
			C_PWM_EN: setting_of = {14'h0000, s.pwm_en};
			C_FILTER: setting_of = {ZERO_BYTE, s.filter};
			C_PAT_EN: setting_of = {ZERO_BYTE, s.pat_en};
			C_PAT_VAL: setting_of = {ZERO_BYTE, s.pat_val};
			C_RISE:   setting_of = {ZERO_BYTE, s.rise_en};
			C_FALL:   setting_of = {ZERO_BYTE, s.fall_en};
			C_BOARD_ID: setting_of = {ZERO_BYTE, 4'h0, s.id_s2};
			C_FW_VER: setting_of = FW_VER;
			C_HW_VER: setting_of = HW_VER;
			default:  setting_of = 16'h0000;
		endcase
	endfunction

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		logic [15:0] val;
		logic [15:0] rb;
		logic [7:0]  rises;
		logic [7:0]  falls;
		val = 16'h0000;
		rb = 16'h0000;
		rises = 8'h00;
		falls = 8'h00;
		nxt_st = st_ff;
		nxt_st.start = 2'b00;
		nxt_st.stop = 2'b00;
		// inputs pass two flops before any use
		nxt_st.in_s1 = i_isolated_input;
		nxt_st.in_s2 = st_ff.in_s1;
		nxt_st.in_prev = st_ff.in_s2;
		nxt_st.id_s1 = i_board_ident;
		nxt_st.id_s2 = st_ff.id_s1;
		// 100us tick divider
		if (st_ff.tick_cnt == TICK_LAST) begin
			nxt_st.tick_cnt = 16'h0000;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.tick_cnt = st_ff.tick_cnt + 16'h0001;
			nxt_st.tick = 1'b0;
		end
		// mailbox writes; reserved byte is accepted and dropped
		if (i_wr) begin
			case (i_addr)
				A_PARAM_LOW:  nxt_st.param_low = i_wdata;
				A_PARAM_HIGH: nxt_st.param_high = i_wdata;
				A_CODE_BYTE: begin
					nxt_st.code = i_wdata;
					nxt_st.req = 1'b1;
				end
				default: ;
			endcase
		end
		// execute one captured request; params latched at code write time
		if (st_ff.req) begin
			nxt_st.req = (i_wr && i_addr == A_CODE_BYTE);
			val = word16(st_ff.param_high, st_ff.param_low);
			case (st_ff.code)
				C_READBACK: begin
					rb = setting_of(st_ff, st_ff.param_low);
					nxt_st.reply_low = rb[7:0];
					nxt_st.reply_high = rb[15:8];
				end
				C_BOARD_ID: nxt_st.reply_low = {4'h0, st_ff.id_s2};
				C_FW_VER: begin
					nxt_st.reply_low = FW_VER[7:0];
					nxt_st.reply_high = FW_VER[15:8];
				end
				C_HW_VER: begin
					nxt_st.reply_low = HW_VER[7:0];
					nxt_st.reply_high = HW_VER[15:8];
				end
				C_HI0: nxt_st.hi0 = val;
				C_LO0: nxt_st.lo0 = val;
				C_HI1: nxt_st.hi1 = val;
				C_LO1: nxt_st.lo1 = val;
				C_BURST0: nxt_st.burst0 = val;
				C_BURST1: nxt_st.burst1 = val;
				C_PWM_EN: begin
					nxt_st.pwm_en = st_ff.param_low[1:0];
					nxt_st.start = st_ff.param_low[1:0];
					nxt_st.stop = ~st_ff.param_low[1:0];
				end
				C_FILTER: nxt_st.filter = st_ff.param_low;
				C_PAT_EN: nxt_st.pat_en = st_ff.param_low;
				C_PAT_VAL: nxt_st.pat_val = st_ff.param_low;
				C_RISE: nxt_st.rise_en = st_ff.param_low;
				C_FALL: nxt_st.fall_en = st_ff.param_low;
				default: ;
			endcase
			nxt_st.reply_echo = st_ff.code;
		end
		// burst end clears the enable bit unless a new enable lands now
		if (pwm_done[0] && !nxt_st.start[0]) begin
			nxt_st.pwm_en[0] = 1'b0;
		end
		if (pwm_done[1] && !nxt_st.start[1]) begin
			nxt_st.pwm_en[1] = 1'b0;
		end
		// masked pattern compare
		nxt_st.match = (((st_ff.in_s2 ^ st_ff.pat_val) & st_ff.pat_en) == 8'h00);
		// edge detection on synchronised levels
		rises = st_ff.in_s2 & ~st_ff.in_prev & st_ff.rise_en;
		falls = ~st_ff.in_s2 & st_ff.in_prev & st_ff.fall_en;
		nxt_st.irq = |(rises | falls);
		// read port
		nxt_st.rdata = ZERO_BYTE;
		if (i_rd) begin
			case (i_addr)
				A_PARAM_LOW:  nxt_st.rdata = st_ff.reply_low;
				A_PARAM_HIGH: nxt_st.rdata = st_ff.reply_high;
				A_CODE_BYTE:  nxt_st.rdata = st_ff.reply_echo;
				A_RESERVED:   nxt_st.rdata = st_ff.in_s2;
				default:      nxt_st.rdata = ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ************************************************
	// pwm channels
	// ************************************************
	mci_pwm u_pulse_out_0 (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_tick  (st_ff.tick),
		.i_start (st_ff.start[0]),
		.i_stop  (st_ff.stop[0]),
		.i_cfg   ({st_ff.hi0, st_ff.lo0, st_ff.burst0, st_ff.pwm_en[0]}),
		.o_pulse (pwm_pulse[0]),
		.o_done  (pwm_done[0])
	);

	mci_pwm u_pulse_out_1 (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_tick  (st_ff.tick),
		.i_start (st_ff.start[1]),
		.i_stop  (st_ff.stop[1]),
		.i_cfg   ({st_ff.hi1, st_ff.lo1, st_ff.burst1, st_ff.pwm_en[1]}),
		.o_pulse (pwm_pulse[1]),
		.o_done  (pwm_done[1])
	);

	// outputs straight from flops
	assign o_rdata         = st_ff.rdata;
	assign o_pulse_out_0   = pwm_pulse[0];
	assign o_pulse_out_1   = pwm_pulse[1];
	assign o_filter_en     = st_ff.filter;
	assign o_pattern_match = st_ff.match;
	assign o_edge_irq      = st_ff.irq;
endmodule

// >>> src/mci_pkg.sv
package mci_pkg;
	// ************************************************
	// mailbox addresses
	// ************************************************
	localparam logic [1:0] ADDR_W        = 2'h2;
	localparam logic [1:0] A_PARAM_LOW   = 2'h0;
	localparam logic [1:0] A_PARAM_HIGH  = 2'h1;
	localparam logic [1:0] A_CODE_BYTE   = 2'h2;
	localparam logic [1:0] A_RESERVED    = 2'h3;
	// ************************************************
	// command codes
	// ************************************************
	localparam logic [7:0] C_CLEAR    = 8'h00;
	localparam logic [7:0] C_READBACK = 8'h07;
	localparam logic [7:0] C_BOARD_ID = 8'h0D;
	localparam logic [7:0] C_FW_VER   = 8'h0E;
	localparam logic [7:0] C_HW_VER   = 8'h0F;
	localparam logic [7:0] C_HI0      = 8'h10;
	localparam logic [7:0] C_LO0      = 8'h11;
	localparam logic [7:0] C_HI1      = 8'h12;
	localparam logic [7:0] C_LO1      = 8'h13;
	localparam logic [7:0] C_BURST0   = 8'h14;
	localparam logic [7:0] C_BURST1   = 8'h15;
	localparam logic [7:0] C_PWM_EN   = 8'h1F;
	localparam logic [7:0] C_FILTER   = 8'h20;
	localparam logic [7:0] C_PAT_EN   = 8'h21;
	localparam logic [7:0] C_PAT_VAL  = 8'h22;
	localparam logic [7:0] C_RISE     = 8'h23;
	localparam logic [7:0] C_FALL     = 8'h24;
	// ************************************************
	// timing, board id width and zero byte
	// ************************************************
	localparam int CLK_MHZ      = 200;
	localparam int TICK_US      = 100;
	localparam int TICK_CYCLES  = CLK_MHZ * TICK_US;
	localparam int BOARD_ID_W   = 4;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// ************************************************
	// carriers
	// ************************************************
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [1:0] addr;
		logic [7:0] wdata;
	} mci_bus_t;
	typedef struct packed {
		logic [15:0] high_cnt;
		logic [15:0] low_cnt;
		logic [15:0] burst;
		logic        enable;
	} mci_pwm_cfg_t;
endpackage

// >>> src/mci_pwm.sv
`timescale 1ns/1ps
module mci_pwm
	import mci_pkg::*;
(
	input  wire logic         i_clk,    // system clock
	input  wire logic         i_srst,   // sync reset
	input  wire logic         i_tick,   // 100us pulse
	input  wire logic         i_start,  // enable written to 1
	input  wire logic         i_stop,   // enable written to 0
	input  wire mci_pwm_cfg_t i_cfg,    // durations and burst
	output logic              o_pulse,  // pwm output
	output logic              o_done    // burst finished, one cycle
);
	import mci_pkg::*;
	typedef struct packed {
		logic        run;
		logic        phase_hi;
		logic [15:0] cnt;
		logic [15:0] left;
		logic        inf;
		logic        pulse;
		logic        done;
	} mci_pwm_st_t;
	mci_pwm_st_t st_ff;
	mci_pwm_st_t nxt_st;

	// phase counter steps on tick only; zero count is treated as one unit
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (i_stop) begin
			nxt_st.run = 1'b0;
		end else if (i_start) begin
			nxt_st.run = 1'b1;
			nxt_st.inf = (i_cfg.burst == 16'h0000);
			nxt_st.left = i_cfg.burst;
			nxt_st.phase_hi = 1'b1;
			nxt_st.cnt = 16'h0001;
		end else if (st_ff.run && i_tick) begin
			if (st_ff.cnt >= (st_ff.phase_hi ? i_cfg.high_cnt : i_cfg.low_cnt)) begin
				nxt_st.cnt = 16'h0001;
				nxt_st.phase_hi = ~st_ff.phase_hi;
				if (!st_ff.phase_hi && !st_ff.inf) begin
					nxt_st.left = st_ff.left - 16'h0001;
					if (st_ff.left == 16'h0001) begin
						nxt_st.run = 1'b0;
						nxt_st.done = 1'b1;
					end
				end
			end else begin
				nxt_st.cnt = st_ff.cnt + 16'h0001;
			end
		end
		nxt_st.pulse = nxt_st.run & nxt_st.phase_hi;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_pulse = st_ff.pulse;
	assign o_done  = st_ff.done;
endmodule

// >>> sim/mci_host.sv
`timescale 1ns/1ps
module mci_host (
	input  wire logic         i_clk,   // system clock
	input  wire logic [7:0]   i_rdata, // read data
	output mci_pkg::mci_bus_t o_bus    // bus request
);
	import mci_pkg::*;
	// bus idle from time zero
	initial o_bus = '0;
	// one-cycle write, launched and released just after rising edges
	task automatic put(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clk);
		o_bus <= '0;
	endtask
	// one-cycle read, data taken in the cycle after the strobe
	task automatic get(input logic [1:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_clk);
		o_bus <= '0;
		@(negedge i_clk);
		d = i_rdata;
	endtask
	// code byte last, since writing it starts execution
	task automatic cmd(input logic [7:0] c, input logic [7:0] hi, input logic [7:0] lo);
		put(A_PARAM_LOW, lo);
		put(A_PARAM_HIGH, hi);
		put(A_RESERVED, 8'h00);
		put(A_CODE_BYTE, c);
	endtask
endmodule

// >>> sim/mci_chk.sv
`timescale 1ns/1ps
module mci_chk #(
	parameter logic [15:0] FW_VER = 16'h0100, // arbitrary value
	parameter logic [15:0] HW_VER = 16'h0100  // arbitrary value
)(
	input wire logic       i_clk,            // clock
	input wire logic       i_srst,           // reset
	input wire logic       i_wr,             // write strobe
	input wire logic       i_rd,             // read strobe
	input wire logic [1:0] i_addr,           // byte select
	input wire logic [7:0] i_wdata,          // write data
	input wire logic [7:0] o_rdata,          // read data
	input wire logic [7:0] i_isolated_input, // pins
	input wire logic [3:0] i_board_ident,    // straps
	input wire logic       o_pulse_out_0,    // pwm 0
	input wire logic [7:0] o_filter_en,      // filter mask
	input wire logic       o_pattern_match,  // match level
	input wire logic       o_edge_irq        // edge pulse
);
	import mci_pkg::*;
	logic [7:0] plo_ff, flt_ff, pen_ff, pat_ff, rise_ff, prev_ff;
	logic [3:0] quiet_ff;
	logic       code_wr;
	assign code_wr = i_wr && i_addr == A_CODE_BYTE;
	// shadow settings; quiet counts cycles free of commands and pin changes
	always_ff @(posedge i_clk) begin
		prev_ff <= i_isolated_input;
		if (i_srst) begin
			{plo_ff, flt_ff, pen_ff, pat_ff, rise_ff} <= '0;
			quiet_ff <= '0;
		end else begin
			if (i_wr && i_addr == A_PARAM_LOW) plo_ff <= i_wdata;
			if (code_wr && i_wdata == C_FILTER) flt_ff <= plo_ff;
			if (code_wr && i_wdata == C_PAT_EN) pen_ff <= plo_ff;
			if (code_wr && i_wdata == C_PAT_VAL) pat_ff <= plo_ff;
			if (code_wr && i_wdata == C_RISE) rise_ff <= plo_ff;
			if (code_wr || i_isolated_input != prev_ff) quiet_ff <= '0;
			else if (quiet_ff != 4'hF) quiet_ff <= quiet_ff + 4'h1;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// command, three cycles without a code write, then reply low byte read
	sequence s_ask(c);
		code_wr && i_wdata == c ##1 !code_wr [*3] ##1 i_rd && i_addr == A_PARAM_LOW;
	endsequence
	property p_echo;
		code_wr ##1 !code_wr ##1 i_rd && i_addr == A_CODE_BYTE |=> o_rdata == $past(i_wdata, 3);
	endproperty
	property p_board;
		s_ask(C_BOARD_ID) |=> o_rdata == {4'h0, i_board_ident};
	endproperty
	property p_fw;
		s_ask(C_FW_VER) |=> o_rdata == FW_VER[7:0];
	endproperty
	property p_snap;
		$stable(i_isolated_input) [*6] ##0 i_rd && i_addr == A_RESERVED
			|=> o_rdata == $past(i_isolated_input);
	endproperty
	property p_filter;
		quiet_ff >= 4'h4 |-> o_filter_en == flt_ff;
	endproperty
	property p_match;
		quiet_ff >= 4'h8 |-> o_pattern_match == (((i_isolated_input ^ pat_ff) & pen_ff) == 8'h00);
	endproperty
	property p_still;
		$stable(i_isolated_input) [*6] |-> !o_edge_irq;
	endproperty
	property p_rise;
		quiet_ff >= 4'h8 && |(i_isolated_input & ~prev_ff & rise_ff) |-> ##[1:6] o_edge_irq;
	endproperty
	property p_off;
		code_wr && i_wdata == C_PWM_EN && !plo_ff[0] |-> ##3 !o_pulse_out_0 [*8];
	endproperty
	a_echo: assert property (p_echo) else $error("echo wrong");
	a_board: assert property (p_board) else $error("board id wrong");
	a_fw: assert property (p_fw) else $error("version wrong");
	a_snap: assert property (p_snap) else $error("snapshot wrong");
	a_filter: assert property (p_filter) else $error("filter mask wrong");
	a_match: assert property (p_match) else $error("pattern match wrong");
	a_still: assert property (p_still) else $error("edge without change");
	a_rise: assert property (p_rise) else $error("rise missed");
	a_off: assert property (p_off) else $error("pwm not stopped");
endmodule
bind mci_top mci_chk #(.FW_VER(FW_VER), .HW_VER(HW_VER)) u_chk (.i_clk, .i_srst, .i_wr,
	.i_rd, .i_addr, .i_wdata, .o_rdata, .i_isolated_input, .i_board_ident,
	.o_pulse_out_0, .o_filter_en, .o_pattern_match, .o_edge_irq);

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
	import mci_pkg::*;
	localparam logic [15:0] FW = 16'h1234; // arbitrary value
	localparam logic [15:0] HW = 16'h5678; // arbitrary value
	logic       i_clk, i_srst, p0, p1, match, irq;
	logic [7:0] o_rdata, in_pins, flt;
	logic [3:0] ident;
	mci_bus_t   bus;
	int         mismatches, n_tests;
	mci_host host (.i_clk(i_clk), .i_rdata(o_rdata), .o_bus(bus));
	mci_top #(.TICK_DIV(10), .FW_VER(FW), .HW_VER(HW)) DUT (.i_clk(i_clk), .i_srst(i_srst),
		.i_wr(bus.wr), .i_rd(bus.rd), .i_addr(bus.addr), .i_wdata(bus.wdata),
		.o_rdata(o_rdata), .i_isolated_input(in_pins), .i_board_ident(ident),
		.o_pulse_out_0(p0), .o_pulse_out_1(p1), .o_filter_en(flt),
		.o_pattern_match(match), .o_edge_irq(irq));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// command, then echo, reply low and reply high
	task automatic ask(input logic [7:0] c, input logic [15:0] v, output logic [15:0] rep);
		logic [7:0] e, lo, hi;
		host.cmd(c, v[15:8], v[7:0]);
		host.get(A_CODE_BYTE, e);
		host.get(A_PARAM_LOW, lo);
		host.get(A_PARAM_HIGH, hi);
		chk(e, c, "echo");
		rep = {hi, lo};
	endtask
	task automatic t_ident();
		logic [15:0] rep;
		ask(C_BOARD_ID, 16'h0000, rep);
		chk(rep[7:0], {4'h0, ident}, "board id");
		ask(C_READBACK, {8'h00, C_BOARD_ID}, rep);
		chk(rep, {12'h000, ident}, "board id readback");
		ask(C_FW_VER, 16'h0000, rep);
		chk(rep, FW, "firmware");
		ask(C_HW_VER, 16'h0000, rep);
		chk(rep, HW, "hardware");
		host.get(A_RESERVED, rep[7:0]);
		chk(rep[7:0], in_pins, "snapshot");
	endtask
	// every setting code except C_PWM_EN stored, then read back; high byte unused for 8-bit ones
	task automatic t_settings();
		logic [7:0]  code [11] = '{C_HI0, C_LO0, C_HI1, C_LO1, C_BURST0, C_BURST1,
			C_FILTER, C_PAT_EN, C_PAT_VAL, C_RISE, C_FALL};
		logic [15:0] rep, v;
		for (int k = 0; k < 11; k++) begin
			v = {8'hC3 ^ 8'(k), 8'h5A + 8'(k)};
			host.cmd(code[k], v[15:8], v[7:0]);
			ask(C_READBACK, {8'h00, code[k]}, rep);
			chk(rep, k < 6 ? v : {8'h00, v[7:0]}, "readback");
		end
		chk(flt, 8'h60, "filter");
	endtask
	task automatic t_pattern();
		host.cmd(C_PAT_EN, 8'h00, 8'h3A);
		host.cmd(C_PAT_VAL, 8'h00, 8'h28);
		in_pins <= 8'hED;
		repeat (8) @(negedge i_clk);
		chk(match, 1'b1, "match ignores idle inputs");
		@(posedge i_clk);
		in_pins <= 8'hFD;
		repeat (8) @(negedge i_clk);
		chk(match, 1'b0, "mismatch");
	endtask
	// only the enabled direction of each pin gives a pulse
	task automatic t_edge();
		logic [7:0] flip [5] = '{8'h04, 8'h04, 8'h40, 8'h40, 8'h01};
		int n;
		host.cmd(C_RISE, 8'h00, 8'h04);
		host.cmd(C_FALL, 8'h00, 8'h40);
		for (int k = 0; k < 5; k++) begin
			@(posedge i_clk);
			in_pins <= in_pins ^ flip[k];
			n = 0;
			repeat (10) begin
				@(negedge i_clk);
				n += int'(irq === 1'b1);
			end
			chk(16'(n), 16'(k == 1 || k == 2), "edge pulses");
		end
	endtask
	// pwm 0 bursts two periods, pwm 1 runs on until switched off
	task automatic t_pwm();
		int          r0, r1, h0;
		logic        l0, l1;
		logic [15:0] rep;
		host.cmd(C_HI0, 8'h00, 8'h02);
		host.cmd(C_LO0, 8'h00, 8'h03);
		host.cmd(C_BURST0, 8'h00, 8'h02);
		host.cmd(C_HI1, 8'h00, 8'h01);
		host.cmd(C_LO1, 8'h00, 8'h01);
		host.cmd(C_BURST1, 8'h00, 8'h00);
		host.cmd(C_PWM_EN, 8'h00, 8'h03);
		{r0, r1, h0, l0, l1} = '0;
		repeat (300) begin
			@(negedge i_clk);
			r0 += int'(p0 === 1'b1 && l0 === 1'b0);
			r1 += int'(p1 === 1'b1 && l1 === 1'b0);
			h0 += int'(p0 === 1'b1);
			l0 = p0;
			l1 = p1;
		end
		chk(16'(r0), 16'd2, "burst periods");
		chk(16'(h0 >= 30 && h0 <= 40), 16'd1, "high time");
		chk(16'(r1 >= 14), 16'd1, "free run");
		ask(C_READBACK, {8'h00, C_PWM_EN}, rep);
		chk(rep[7:0], 8'h02, "enable cleared");
		host.cmd(C_PWM_EN, 8'h00, 8'h00);
		repeat (4) @(negedge i_clk);
		chk(p1, 1'b0, "pwm off");
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// 200 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// reset, then the scenarios in turn
	initial begin
		i_srst = 1'b1;
		in_pins = 8'hA6;
		ident = 4'hB;
		repeat (20) @(posedge i_clk);
		i_srst <= 1'b0;
		t_ident();
		t_settings();
		t_pattern();
		t_edge();
		t_pwm();
		give_verdict();
	end
	// watchdog well past the expected run of under a thousand cycles
	initial begin
		repeat (20000) @(posedge i_clk);
		mismatches++;
		give_verdict();
	end
endmodule
